// *** dv/srq_checker.sv ***
`timescale 1ns/10ps
`include "srq_cfg.svh"

module srq_checker
  import srq_pkg::*;
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  // Watched inputs
  input wire logic IF_OVERLOAD_IN,
  input wire logic DCL_IN,
  input wire logic MSG_START_IN,
  input wire logic SPOLL_IN,
  input wire logic CMD_VALID_IN,
  input wire cmd_t CMD_IN,
  // Watched outputs
  input wire resp_t RESP_OUT,
  input wire spoll_t SPOLL_OUT,
  input wire logic SRQ_OUT,
  input wire logic OVERLOAD_INDICATOR_OUT,
  input wire logic CLEAR_OUTBUF_OUT,
  input wire logic FLUSH_INPUT_OUT,
  input wire logic ABORT_CMD_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  // ----------------------------------------------------------------
  // Last query kind, for the unused-bit checks
  // ----------------------------------------------------------------
  logic rd_ce;
  logic [15:0] unused;
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rd_ce <= 1'b0;
      unused <= 16'h0000;
    end else begin
      rd_ce <= CMD_VALID_IN && (CMD_IN.op inside {OP_READ_COND, OP_READ_EVENT});
      unused <= (CMD_IN.sel == SEL_LIMIT) ? ~`LIM_USED_MASK :
                (CMD_IN.sel == SEL_POWER) ? ~`POW_USED_MASK : ~`SYNC_USED_MASK;
    end
  end
  ovl_copy_a: assert property (OVERLOAD_INDICATOR_OUT == $past(IF_OVERLOAD_IN))
    else $error("overload indicator does not follow overload");
  read_answer_a: assert property (CMD_VALID_IN && !(CMD_IN.op inside {OP_NOP,
    OP_WRITE_ENA, OP_WRITE_PTR, OP_WRITE_NTR, OP_STAT_PRESET, OP_CLEAR_STATUS, OP_WRITE_SRE,
    OP_WRITE_ESE}) |=> RESP_OUT.valid) else $error("query got no answer");
  no_unasked_a: assert property (RESP_OUT.valid |-> $past(CMD_VALID_IN))
    else $error("answer without query");
  poll_answer_a: assert property (SPOLL_IN |=> SPOLL_OUT.valid)
    else $error("serial poll got no status byte");
  poll_clear_a: assert property (SPOLL_IN |=> !SRQ_OUT)
    else $error("service request stays after poll");
  bit15_zero_a: assert property (RESP_OUT.valid && rd_ce |-> !RESP_OUT.data[15])
    else $error("bit 15 reads one");
  unused_zero_a: assert property (RESP_OUT.valid && rd_ce |-> !(RESP_OUT.data & unused))
    else $error("unused status bit reads one");
  dcl_flush_a: assert property (DCL_IN |=> FLUSH_INPUT_OUT && ABORT_CMD_OUT &&
    CLEAR_OUTBUF_OUT) else $error("device clear did not flush");
  msg_clear_a: assert property (MSG_START_IN |=> CLEAR_OUTBUF_OUT)
    else $error("new message kept output buffer");
  // Main scenarios
  srq_seen_c: cover property ($rose(SRQ_OUT));
  poll_rqs_c: cover property (SPOLL_OUT.valid && SPOLL_OUT.stb[6]);
  dcl_seen_c: cover property (DCL_IN);
endmodule : srq_checker

bind status_reporting_srq srq_checker u_srq_checker (.CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN),
  .IF_OVERLOAD_IN(IF_OVERLOAD_IN), .DCL_IN(DCL_IN), .MSG_START_IN(MSG_START_IN),
  .SPOLL_IN(SPOLL_IN), .CMD_VALID_IN(CMD_VALID_IN), .CMD_IN(CMD_IN), .RESP_OUT(RESP_OUT),
  .SPOLL_OUT(SPOLL_OUT), .SRQ_OUT(SRQ_OUT), .OVERLOAD_INDICATOR_OUT(OVERLOAD_INDICATOR_OUT),
  .CLEAR_OUTBUF_OUT(CLEAR_OUTBUF_OUT), .FLUSH_INPUT_OUT(FLUSH_INPUT_OUT),
  .ABORT_CMD_OUT(ABORT_CMD_OUT));

// *** dv/srq_host_model.sv ***
`timescale 1ns/10ps

module srq_host_model (
  // Clock
  input wire logic clk_in,
  // Service request seen on the bus
  input wire logic srq_in,
  // Serial poll issued
  output logic spoll_out
);
  logic slow; // Alternates prompt and slow polling
  // Controller polls after every service request
  initial begin
    spoll_out = 1'b0;
    slow = 1'b0;
    forever begin
      @(negedge clk_in);
      if (srq_in === 1'b1) begin
        repeat (slow ? 3 : 0) @(negedge clk_in);
        spoll_out <= 1'b1;
        @(negedge clk_in);
        spoll_out <= 1'b0;
        repeat (2) @(negedge clk_in);
        slow = !slow;
      end
    end
  end
endmodule : srq_host_model

// *** dv/status_reporting_srq_tb_top.sv ***
`timescale 1ns/10ps
`include "srq_cfg.svh"

module status_reporting_srq_tb_top;
  import srq_pkg::*;
  logic clk = 0, arst_n = 0, lim1 = 0, lim2 = 0, ovl = 0, oper = 0, mav = 0, push = 0;
  logic psc = 1, dcl = 0, msg = 0, spoll, cvalid = 0, srq, ind, cob, fli, abo;
  sync_cond_t sync = '0;
  cmd_t cmd = '0;
  logic [7:0] esr_ev = 8'h00;
  logic [15:0] code = 16'h0000;
  logic [15:0] ec [3];
  resp_t resp;
  spoll_t sp;
  int n_fail = 0, comparisons = 0, cyc = 0, k;
  logic [31:0] seed = 32'h1B6F0F3B;
  logic [15:0] rq [$]; // Expected answers
  logic [7:0] sq [$]; // Expected polled status bytes
  logic [7:0] smask [3] = '{8'h10, 8'h80, 8'h04};
  logic [7:0] sstb [3] = '{8'h50, 8'hC0, 8'h44};
  always #25 clk = ~clk;
  status_reporting_srq u_status_reporting_srq (.CLK_IN(clk), .ARST_N_IN(arst_n),
    .LIMIT1_FAIL_IN(lim1), .LIMIT2_FAIL_IN(lim2), .IF_OVERLOAD_IN(ovl), .SYNC_COND_IN(sync),
    .ESR_EVENTS_IN(esr_ev), .OPER_SUM_IN(oper), .MAV_IN(mav), .ERR_PUSH_IN(push),
    .ERR_CODE_IN(code), .PSC_IN(psc), .DCL_IN(dcl), .MSG_START_IN(msg), .SPOLL_IN(spoll),
    .CMD_VALID_IN(cvalid), .CMD_IN(cmd), .RESP_OUT(resp), .SPOLL_OUT(sp), .SRQ_OUT(srq),
    .OVERLOAD_INDICATOR_OUT(ind), .CLEAR_OUTBUF_OUT(cob), .FLUSH_INPUT_OUT(fli),
    .ABORT_CMD_OUT(abo));
  srq_host_model u_srq_host_model (.clk_in(clk), .srq_in(srq), .spoll_out(spoll));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task give_verdict;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task w(input int n);
    repeat (n) @(negedge clk);
  endtask : w
  task op(input cmd_op_t o, input reg_sel_t s, input logic [15:0] d);
    @(negedge clk);
    cvalid = 1;
    cmd = '{o, s, d};
    @(negedge clk);
    cvalid = 0;
  endtask : op
  task rd(input cmd_op_t o, input reg_sel_t s, input logic [15:0] e);
    rq.push_back(e);
    op(o, s, 16'h0000);
  endtask : rd
  task perr(input logic [15:0] c);
    @(negedge clk);
    push = 1;
    code = c;
    @(negedge clk);
    push = 0;
  endtask : perr
  task wsrq(input logic [7:0] stb);
    int i;
    sq.push_back(stb);
    for (i = 0; i < 30 && srq !== 1'b1; i++) @(negedge clk);
    check("srq", {15'h0000, srq}, 16'h0001);
    for (i = 0; i < 30 && srq !== 1'b0; i++) @(negedge clk);
    check("srq_clear", {15'h0000, srq}, 16'h0000);
  endtask : wsrq
  // Output monitor takes the oldest note for each answer
  always @(negedge clk) begin
    if (resp.valid === 1'b1) check("resp", resp.data, rq.size() ? rq.pop_front() : 'x);
    if (sp.valid === 1'b1) check("stb", {8'h00, sp.stb}, {8'h00, sq.size() ? sq.pop_front() : 8'hxx});
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      n_fail++;
      give_verdict;
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    w(5);
    arst_n = 1;
    w(3);
    rd(OP_READ_PTR, SEL_LIMIT, 16'hFFFF);
    rd(OP_READ_NTR, SEL_POWER, 16'h0000);
    rd(OP_READ_ENA, SEL_SYNC, 16'h0000);
    rd(OP_READ_ERROR, SEL_LIMIT, 16'h0000);
    $display("test reset done");
    lim1 = 1;
    w(3);
    rd(OP_READ_COND, SEL_LIMIT, 16'h0001);
    lim2 = 1;
    w(3);
    rd(OP_READ_COND, SEL_LIMIT, 16'h0003);
    rd(OP_READ_EVENT, SEL_LIMIT, 16'h0003);
    rd(OP_READ_EVENT, SEL_LIMIT, 16'h0000);
    op(OP_WRITE_PTR, SEL_LIMIT, 16'h0000);
    op(OP_WRITE_NTR, SEL_LIMIT, 16'h0001);
    lim1 = 0;
    lim2 = 0;
    w(3);
    rd(OP_READ_EVENT, SEL_LIMIT, 16'h0001);
    op(OP_STAT_PRESET, SEL_LIMIT, 16'h0000);
    rd(OP_READ_PTR, SEL_LIMIT, 16'hFFFF);
    rd(OP_READ_NTR, SEL_LIMIT, 16'h0000);
    ovl = 1;
    w(3);
    rd(OP_READ_COND, SEL_POWER, 16'h0004);
    rd(OP_READ_EVENT, SEL_POWER, 16'h0004);
    for (k = 0; k < 4; k++) begin
      seed = xs(seed);
      sync = seed[3:0];
      w(3);
      rd(OP_READ_COND, SEL_SYNC, {12'h000, seed[3:0]});
    end
    $display("test events done");
    op(OP_WRITE_ESE, SEL_LIMIT, 16'h0001);
    op(OP_WRITE_SRE, SEL_LIMIT, 16'h0020);
    esr_ev = 8'h01;
    w(1);
    esr_ev = 8'h00;
    wsrq(8'h60);
    rd(OP_READ_ESR, SEL_LIMIT, 16'h0081);
    for (k = 0; k < 3; k++) begin
      op(OP_WRITE_SRE, SEL_LIMIT, {8'h00, smask[k]});
      seed = xs(seed);
      if (k == 0) mav = 1;
      if (k == 1) oper = 1;
      if (k == 2) perr(seed[15:0]);
      wsrq(sstb[k]);
      mav = 0;
      oper = 0;
      if (k == 2) rd(OP_READ_ERROR, SEL_LIMIT, seed[15:0]);
    end
    $display("test service request done");
    sq.push_back(8'h44);
    for (k = 0; k < 3; k++) begin
      seed = xs(seed);
      ec[k] = seed[15:0];
      perr(ec[k]);
    end
    for (k = 0; k < 3; k++) rd(OP_READ_ERROR, SEL_LIMIT, ec[k]);
    rd(OP_READ_ERROR, SEL_LIMIT, 16'h0000);
    perr(16'h1234);
    wsrq(8'h44);
    rd(OP_READ_STB, SEL_LIMIT, 16'h0044);
    lim1 = 1;
    w(3);
    op(OP_CLEAR_STATUS, SEL_LIMIT, 16'h0000);
    rd(OP_READ_ERROR, SEL_LIMIT, 16'h0000);
    rd(OP_READ_EVENT, SEL_LIMIT, 16'h0000);
    $display("test error queue done");
    @(negedge clk) dcl = 1;
    @(negedge clk) dcl = 0;
    check("flush", {13'h0000, fli, abo, cob}, 16'h0007);
    rd(OP_READ_SRE, SEL_LIMIT, 16'h0004);
    @(negedge clk) msg = 1;
    @(negedge clk) msg = 0;
    check("outbuf", {15'h0000, cob}, 16'h0001);
    w(3);
    $display("test clears done");
    give_verdict;
  end
endmodule : status_reporting_srq_tb_top

// *** hdl/error_queue.sv ***
`timescale 1ns/10ps
`include "srq_cfg.svh"

module error_queue (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Entry side
  input wire logic push_in,
  input wire logic [`STAT_W-1:0] code_in,
  // Read side
  input wire logic pop_in,
  input wire logic clear_in,
  output logic [`STAT_W-1:0] head_out,
  output logic not_empty_out
);

  logic [`STAT_W-1:0] mem [`ERRQ_DEPTH]; // Entry storage
  logic [`ERRQ_PTR_W-1:0] rd_ptr;
  logic [`ERRQ_PTR_W-1:0] wr_ptr;
  logic [`ERRQ_CNT_W-1:0] count;
  logic [`ERRQ_PTR_W-1:0] next_rd_ptr;
  logic [`ERRQ_PTR_W-1:0] next_wr_ptr;
  logic [`ERRQ_CNT_W-1:0] next_count;
  logic do_pop;
  logic do_push;

  assign not_empty_out = (count != '0);
  // Empty queue reads as the no-error code
  assign head_out = not_empty_out ? mem[rd_ptr] : `NO_ERROR_CODE;

  // Pointer and count update
  always_comb begin
    do_pop = pop_in && not_empty_out && !clear_in;
    // A full queue drops the newest entry
    do_push = push_in && (clear_in || (count != `ERRQ_CNT_W'(`ERRQ_DEPTH)));
    next_rd_ptr = rd_ptr;
    next_wr_ptr = wr_ptr;
    next_count = count;
    if (clear_in) begin
      next_rd_ptr = '0;
      next_wr_ptr = '0;
      next_count = '0;
    end
    if (do_pop) begin
      next_rd_ptr = rd_ptr + 1'b1;
      next_count = next_count - 1'b1;
    end
    if (do_push) begin
      next_wr_ptr = next_wr_ptr + 1'b1;
      next_count = next_count + 1'b1;
    end
  end

  // Pointer registers
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count <= '0;
    end else begin
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count <= next_count;
    end
  end

  // Entry storage, written at the slot the push lands in
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < `ERRQ_DEPTH; i++) begin
        mem[i] <= `NO_ERROR_CODE;
      end
    end else if (do_push) begin
      mem[clear_in ? '0 : wr_ptr] <= code_in;
    end
  end

endmodule : error_queue

// *** hdl/srq_cfg.svh ***
// Operation
// - Limit line one violation sets bit 0
// - Limit line two violation sets bit 1
// - IF overload sets bit 2, lights indicator
// - Bit 15 of sub-registers reads zero; only the condition and event parts mask it, enable and filter parts keep it
// - Sync register flags sync and premeasurement faults
// - Enabled status byte bits 2,3,4,5,7 request service
// - Enable masks let any bit propagate upward
// - Operation complete plus enables yields service request
// - Service request is the only unsolicited signal
// - Serial poll returns status byte quickly
// - Queries answer the register bit pattern
// - One queue entry per error, one per read
// - Empty queue answers zero, no error
// - Events cleared by status-clear power-on or clear-status
// - Device clear flushes buffers, keeps settings
// - Power-on always aborts processing, flushes input
// - New program message discards output buffer
// - Preset fills positive filters, clears negative, enables
// - Event read returns and clears contents
// - Enabled event gives rising summary bit
`ifndef SRQ_CFG_SVH
`define SRQ_CFG_SVH

// ----------------------------------------------------------------
// Status register layout
// ----------------------------------------------------------------
`define STAT_W 16
`define LIM1_BIT 0
`define LIM2_BIT 1
`define OVERLOAD_INDICATOR_BIT 2
`define ALWAYS0_BIT 15
`define SYNC_NOTFOUND_BIT 0
`define BURST_NOTFOUND_BIT 1
`define PREMEAS_HIGH_BIT 2
`define PREMEAS_LOW_BIT 3
`define LIM_USED_MASK 16'h0003
`define POW_USED_MASK 16'h0004
`define SYNC_USED_MASK 16'h000F

// ----------------------------------------------------------------
// Reset and preset values
// ----------------------------------------------------------------
`define EVENT_RESET 16'h0000
`define PTR_PRESET 16'hFFFF
`define NTR_PRESET 16'h0000
`define ENA_PRESET 16'h0000

// ----------------------------------------------------------------
// Status byte and standard event register
// ----------------------------------------------------------------
`define STB_W 8
`define STB_ERRQ_BIT 2
`define STB_QUES_BIT 3
`define STB_MAV_BIT 4
`define STB_ESB_BIT 5
`define STB_MSS_BIT 6
`define STB_OPER_BIT 7
`define SRE_MASK 8'hBC
`define SRE_RESET 8'h00
`define ESE_RESET 8'h00
`define ESR_RESET 8'h00
`define ESR_PON_BIT 7

// ----------------------------------------------------------------
// Error queue
// ----------------------------------------------------------------
`define ERRQ_DEPTH 8
`define ERRQ_PTR_W 3
`define ERRQ_CNT_W 4
`define NO_ERROR_CODE 16'h0000

`endif

// *** hdl/srq_pkg.sv ***
`include "srq_cfg.svh"

package srq_pkg;

  // ----------------------------------------------------------------
  // Command set of the status subsystem
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP,
    OP_READ_COND,
    OP_READ_EVENT,
    OP_READ_ENA,
    OP_READ_PTR,
    OP_READ_NTR,
    OP_WRITE_ENA,
    OP_WRITE_PTR,
    OP_WRITE_NTR,
    OP_STAT_PRESET,
    OP_CLEAR_STATUS,
    OP_READ_STB,
    OP_WRITE_SRE,
    OP_READ_SRE,
    OP_WRITE_ESE,
    OP_READ_ESE,
    OP_READ_ESR,
    OP_READ_ERROR
  } cmd_op_t;

  // Status sub-register selector
  typedef enum logic [1:0] {
    SEL_LIMIT,
    SEL_POWER,
    SEL_SYNC
  } reg_sel_t;

  // One command from the parser
  typedef struct packed {
    cmd_op_t op;
    reg_sel_t sel;
    logic [`STAT_W-1:0] data;
  } cmd_t;

  // Answer to a query
  typedef struct packed {
    logic valid;
    logic [`STAT_W-1:0] data;
  } resp_t;

  // Serial poll answer
  typedef struct packed {
    logic valid;
    logic [`STB_W-1:0] stb;
  } spoll_t;

  // Sync and premeasurement conditions
  typedef struct packed {
    logic premeas_low;
    logic premeas_high;
    logic burst_not_found;
    logic sync_not_found;
  } sync_cond_t;

endpackage : srq_pkg

// *** hdl/status_reg_group.sv ***
`timescale 1ns/10ps
`include "srq_cfg.svh"

module status_reg_group #(
  parameter logic [`STAT_W-1:0] USED_MASK = `LIM_USED_MASK
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Condition source
  input wire logic [`STAT_W-1:0] cond_in,
  // Mask writes
  input wire logic wr_ena_in,
  input wire logic wr_ptr_in,
  input wire logic wr_ntr_in,
  input wire logic [`STAT_W-1:0] wr_data_in,
  // Bulk effects
  input wire logic preset_in,
  input wire logic clear_events_in,
  input wire logic read_event_in,
  // Register parts
  output logic [`STAT_W-1:0] cond_out,
  output logic [`STAT_W-1:0] event_out,
  output logic [`STAT_W-1:0] ena_out,
  output logic [`STAT_W-1:0] ptr_out,
  output logic [`STAT_W-1:0] ntr_out,
  output logic summary_out
);

  logic [`STAT_W-1:0] keep; // Bits that exist, bit 15 never
  logic [`STAT_W-1:0] cond_prev; // Condition one cycle ago
  logic [`STAT_W-1:0] next_cond_prev;
  logic [`STAT_W-1:0] next_event;
  logic [`STAT_W-1:0] next_ena;
  logic [`STAT_W-1:0] next_ptr;
  logic [`STAT_W-1:0] next_ntr;
  logic [`STAT_W-1:0] hit; // Filtered transitions

  assign keep = USED_MASK & ~(`STAT_W'(1) << `ALWAYS0_BIT);

  // Condition part is the live, masked level
  assign cond_out = cond_in & keep;

  // Summary ORs enabled events; rises as an enabled event sets
  assign summary_out = |(event_out & ena_out);

  // Next values of the event part and the masks
  always_comb begin
    next_cond_prev = cond_out;
    hit = ((cond_out & ~cond_prev) & ptr_out) | ((~cond_out & cond_prev) & ntr_out);
    next_event = event_out;
    // Clear by read or clear command; a new transition wins
    if (clear_events_in || read_event_in) begin
      next_event = `EVENT_RESET;
    end
    next_event = (next_event | hit) & keep;
    next_ena = wr_ena_in ? wr_data_in : ena_out;
    next_ptr = wr_ptr_in ? wr_data_in : ptr_out;
    next_ntr = wr_ntr_in ? wr_data_in : ntr_out;
    // Preset restores the filters and clears the enables
    if (preset_in) begin
      next_ena = `ENA_PRESET;
      next_ptr = `PTR_PRESET;
      next_ntr = `NTR_PRESET;
    end
  end

  // Register the parts
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cond_prev <= `EVENT_RESET;
      event_out <= `EVENT_RESET;
      ena_out <= `ENA_PRESET;
      ptr_out <= `PTR_PRESET;
      ntr_out <= `NTR_PRESET;
    end else begin
      cond_prev <= next_cond_prev;
      event_out <= next_event;
      ena_out <= next_ena;
      ptr_out <= next_ptr;
      ntr_out <= next_ntr;
    end
  end

endmodule : status_reg_group

// *** hdl/status_reporting_srq.sv ***
`timescale 1ns/10ps
`include "srq_cfg.svh"

module status_reporting_srq
  import srq_pkg::*;
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  // Measurement conditions
  input wire logic LIMIT1_FAIL_IN,
  input wire logic LIMIT2_FAIL_IN,
  input wire logic IF_OVERLOAD_IN,
  input wire sync_cond_t SYNC_COND_IN,
  // Other status sources
  input wire logic [`STB_W-1:0] ESR_EVENTS_IN,
  input wire logic OPER_SUM_IN,
  input wire logic MAV_IN,
  input wire logic ERR_PUSH_IN,
  input wire logic [`STAT_W-1:0] ERR_CODE_IN,
  // Power-on flag and bus clears
  input wire logic PSC_IN,
  input wire logic DCL_IN,
  input wire logic MSG_START_IN,
  input wire logic SPOLL_IN,
  // Commands
  input wire logic CMD_VALID_IN,
  input wire cmd_t CMD_IN,
  // Answers
  output resp_t RESP_OUT,
  output spoll_t SPOLL_OUT,
  // Service request and indicator
  output logic SRQ_OUT,
  output logic OVERLOAD_INDICATOR_OUT,
  // Buffer and parser clears
  output logic CLEAR_OUTBUF_OUT,
  output logic FLUSH_INPUT_OUT,
  output logic ABORT_CMD_OUT
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int NGRP = 3; // Limit, power, sync
  localparam logic [`STAT_W-1:0] USED [NGRP] = '{`LIM_USED_MASK, `POW_USED_MASK,
    `SYNC_USED_MASK};

  logic por_pending; // First cycle after power-on
  logic next_por_pending;
  logic cmd_ok; // Command accepted this cycle
  logic psc_clear; // Power-on with status-clear flag set
  logic cls; // Clear-status command
  logic clear_events; // Bulk event-part clear: status-clear power-on or clear-status
  logic stat_preset; // Filter and enable preset
  logic [`STAT_W-1:0] grp_cond_in [NGRP];
  logic [`STAT_W-1:0] grp_cond [NGRP];
  logic [`STAT_W-1:0] grp_event [NGRP];
  logic [`STAT_W-1:0] grp_ena [NGRP];
  logic [`STAT_W-1:0] grp_ptr [NGRP];
  logic [`STAT_W-1:0] grp_ntr [NGRP];
  logic [NGRP-1:0] grp_sum; // Group summaries
  logic [NGRP-1:0] sel_hit; // Selected group
  logic [`STB_W-1:0] sre; // Service request enable
  logic [`STB_W-1:0] ese; // Standard event enable
  logic [`STB_W-1:0] esr; // Standard event register
  logic [`STB_W-1:0] next_sre;
  logic [`STB_W-1:0] next_ese;
  logic [`STB_W-1:0] next_esr;
  logic [`STB_W-1:0] stb; // Status byte with master summary
  logic mss; // Master summary
  logic mss_prev;
  logic rqs; // Pending service request
  logic next_rqs;
  logic errq_not_empty;
  logic [`STAT_W-1:0] errq_head;
  logic errq_pop;
  logic errq_clear;
  resp_t next_resp;
  spoll_t next_spoll;
  logic next_clear_outbuf;
  logic next_flush_input;
  logic next_abort_cmd;
  logic next_overload;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Commands are ignored while the power-on cycle aborts processing
  assign cmd_ok = CMD_VALID_IN && !por_pending;
  assign psc_clear = por_pending && PSC_IN;
  assign cls = cmd_ok && (CMD_IN.op == OP_CLEAR_STATUS);
  assign clear_events = psc_clear || cls;
  assign stat_preset = psc_clear || (cmd_ok && (CMD_IN.op == OP_STAT_PRESET));
  assign errq_clear = por_pending || cls;
  assign errq_pop = cmd_ok && (CMD_IN.op == OP_READ_ERROR);

  // One-hot group select
  always_comb begin
    sel_hit = '0;
    unique case (CMD_IN.sel)
      SEL_LIMIT: sel_hit[0] = 1'b1;
      SEL_POWER: sel_hit[1] = 1'b1;
      SEL_SYNC: sel_hit[2] = 1'b1;
      default: sel_hit = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Condition sources
  // ----------------------------------------------------------------
  // Place each condition at its documented bit
  always_comb begin
    grp_cond_in[0] = '0;
    grp_cond_in[1] = '0;
    grp_cond_in[2] = '0;
    grp_cond_in[0][`LIM1_BIT] = LIMIT1_FAIL_IN;
    grp_cond_in[0][`LIM2_BIT] = LIMIT2_FAIL_IN;
    grp_cond_in[1][`OVERLOAD_INDICATOR_BIT] = IF_OVERLOAD_IN;
    grp_cond_in[2][`SYNC_NOTFOUND_BIT] = SYNC_COND_IN.sync_not_found;
    grp_cond_in[2][`BURST_NOTFOUND_BIT] = SYNC_COND_IN.burst_not_found;
    grp_cond_in[2][`PREMEAS_HIGH_BIT] = SYNC_COND_IN.premeas_high;
    grp_cond_in[2][`PREMEAS_LOW_BIT] = SYNC_COND_IN.premeas_low;
  end

  // ----------------------------------------------------------------
  // Status sub-registers
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NGRP; g++) begin : grp
    status_reg_group #(
      .USED_MASK(USED[g])
    ) group_inst (
      .clk_in(CLK_IN),
      .arst_n_in(ARST_N_IN),
      .cond_in(grp_cond_in[g]),
      .wr_ena_in(cmd_ok && sel_hit[g] && (CMD_IN.op == OP_WRITE_ENA)),
      .wr_ptr_in(cmd_ok && sel_hit[g] && (CMD_IN.op == OP_WRITE_PTR)),
      .wr_ntr_in(cmd_ok && sel_hit[g] && (CMD_IN.op == OP_WRITE_NTR)),
      .wr_data_in(CMD_IN.data),
      .preset_in(stat_preset),
      .clear_events_in(clear_events),
      .read_event_in(cmd_ok && sel_hit[g] && (CMD_IN.op == OP_READ_EVENT)),
      .cond_out(grp_cond[g]),
      .event_out(grp_event[g]),
      .ena_out(grp_ena[g]),
      .ptr_out(grp_ptr[g]),
      .ntr_out(grp_ntr[g]),
      .summary_out(grp_sum[g])
    );
  end

  // ----------------------------------------------------------------
  // Error queue
  // ----------------------------------------------------------------
  error_queue errq_inst (
    .clk_in(CLK_IN),
    .arst_n_in(ARST_N_IN),
    .push_in(ERR_PUSH_IN),
    .code_in(ERR_CODE_IN),
    .pop_in(errq_pop),
    .clear_in(errq_clear),
    .head_out(errq_head),
    .not_empty_out(errq_not_empty)
  );

  // ----------------------------------------------------------------
  // Status byte and service request
  // ----------------------------------------------------------------
  // Assemble the status byte from its summaries
  always_comb begin
    stb = '0;
    stb[`STB_ERRQ_BIT] = errq_not_empty;
    stb[`STB_QUES_BIT] = |grp_sum;
    stb[`STB_MAV_BIT] = MAV_IN;
    stb[`STB_ESB_BIT] = |(esr & ese);
    stb[`STB_OPER_BIT] = OPER_SUM_IN;
    mss = |(stb & sre & `SRE_MASK);
    stb[`STB_MSS_BIT] = mss;
  end

  // Standard event, enables and request flag
  always_comb begin
    next_esr = esr;
    next_sre = sre;
    next_ese = ese;
    next_rqs = rqs;
    // Clears first, so events in the same cycle survive
    if (clear_events || (cmd_ok && (CMD_IN.op == OP_READ_ESR))) begin
      next_esr = `ESR_RESET;
    end
    next_esr = next_esr | ESR_EVENTS_IN;
    if (por_pending) begin
      next_esr[`ESR_PON_BIT] = 1'b1;
    end
    if (psc_clear) begin
      next_sre = `SRE_RESET;
      next_ese = `ESE_RESET;
    end else if (cmd_ok && (CMD_IN.op == OP_WRITE_SRE)) begin
      next_sre = CMD_IN.data[`STB_W-1:0];
    end else if (cmd_ok && (CMD_IN.op == OP_WRITE_ESE)) begin
      next_ese = CMD_IN.data[`STB_W-1:0];
    end
    // Poll or clear drops the request; a new rising summary wins
    if (SPOLL_IN || clear_events) begin
      next_rqs = 1'b0;
    end
    if (mss && !mss_prev) begin
      next_rqs = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Answers and clear pulses
  // ----------------------------------------------------------------
  // Query answers are the plain bit pattern of the register part
  always_comb begin
    next_resp.valid = 1'b0;
    next_resp.data = '0;
    if (cmd_ok) begin
      next_resp.valid = 1'b1;
      unique case (CMD_IN.op)
        OP_READ_COND: begin
          next_resp.data = |sel_hit ? grp_cond[CMD_IN.sel] : '0;
        end
        OP_READ_EVENT: begin
          next_resp.data = |sel_hit ? grp_event[CMD_IN.sel] : '0;
        end
        OP_READ_ENA: begin
          next_resp.data = |sel_hit ? grp_ena[CMD_IN.sel] : '0;
        end
        OP_READ_PTR: begin
          next_resp.data = |sel_hit ? grp_ptr[CMD_IN.sel] : '0;
        end
        OP_READ_NTR: begin
          next_resp.data = |sel_hit ? grp_ntr[CMD_IN.sel] : '0;
        end
        OP_READ_STB: begin
          next_resp.data = {{(`STAT_W-`STB_W){1'b0}}, stb};
        end
        OP_READ_SRE: begin
          next_resp.data = {{(`STAT_W-`STB_W){1'b0}}, sre};
        end
        OP_READ_ESE: begin
          next_resp.data = {{(`STAT_W-`STB_W){1'b0}}, ese};
        end
        OP_READ_ESR: begin
          next_resp.data = {{(`STAT_W-`STB_W){1'b0}}, esr};
        end
        OP_READ_ERROR: begin
          next_resp.data = errq_head;
        end
        default: begin
          // Writes and actions give no answer
          next_resp.valid = 1'b0;
        end
      endcase
    end
    // Serial poll carries the request flag in the summary bit
    next_spoll.valid = SPOLL_IN;
    next_spoll.stb = stb;
    next_spoll.stb[`STB_MSS_BIT] = rqs;
    // Power-on and device clear abort the parser and flush input
    next_flush_input = por_pending || DCL_IN;
    next_abort_cmd = por_pending || DCL_IN;
    next_clear_outbuf = por_pending || DCL_IN || MSG_START_IN;
    next_overload = IF_OVERLOAD_IN;
    next_por_pending = 1'b0;
  end

  // Register all control state and outputs
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      por_pending <= 1'b1;
      sre <= `SRE_RESET;
      ese <= `ESE_RESET;
      esr <= `ESR_RESET;
      rqs <= 1'b0;
      mss_prev <= 1'b0;
      RESP_OUT <= '0;
      SPOLL_OUT <= '0;
      CLEAR_OUTBUF_OUT <= 1'b0;
      FLUSH_INPUT_OUT <= 1'b0;
      ABORT_CMD_OUT <= 1'b0;
      OVERLOAD_INDICATOR_OUT <= 1'b0;
    end else begin
      por_pending <= next_por_pending;
      sre <= next_sre;
      ese <= next_ese;
      esr <= next_esr;
      rqs <= next_rqs;
      mss_prev <= mss;
      RESP_OUT <= next_resp;
      SPOLL_OUT <= next_spoll;
      CLEAR_OUTBUF_OUT <= next_clear_outbuf;
      FLUSH_INPUT_OUT <= next_flush_input;
      ABORT_CMD_OUT <= next_abort_cmd;
      OVERLOAD_INDICATOR_OUT <= next_overload;
    end
  end

  // Only unsolicited signal toward the controller
  assign SRQ_OUT = rqs;

endmodule : status_reporting_srq
